// ===== src/clock_distribution_sysref_sync.sv
// fourteen-channel divider, delay, sync and SYSREF routing logic
`timescale 1ns/1ps
module clock_distribution_sysref_sync
  import clock_distribution_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic referenceCleanupLoop,
  input wire logic highFrequencyLoop,
  input wire logic highFrequencyLoopLocked,
  input wire logic oscillatorClockInput,
  input wire logic externalSysrefInput,
  input wire logic sysrefRequestPin,
  output logic [NUM_CHANNELS-1:0] channelOut,
  output logic [NUM_CHANNELS-1:0] fineDelayEnable,
  output logic [NUM_CHANNELS-1:0][3:0] fineDelayCode,
  output logic [NUM_CHANNELS-1:0] channelPowerdown,
  output logic [NUM_CHANNELS-1:0] regulatorPowerdown
);

  // ====================================================================
  // helpers
  function automatic logic risingEdge(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction

  function automatic logic fallingEdge(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  // address of one byte inside a channel's group
  function automatic logic [15:0] chanAddr(input int ch, input logic [1:0] sel);
    return CH_BASE_ADDR + 16'(ch * CH_STRIDE) + {14'h0000, sel};
  endfunction

  // ====================================================================
  // pin synchronisers; stage one feeds stage two only
  localparam int NUM_PINS = 6;
  logic [NUM_PINS-1:0] pinMeta_q;
  logic [NUM_PINS-1:0] pinSync_q;
  logic [NUM_PINS-1:0] pinPrev_q;
  logic [NUM_PINS-1:0] pinRaw;

  assign pinRaw = {sysrefRequestPin, externalSysrefInput, oscillatorClockInput,
                   highFrequencyLoopLocked, highFrequencyLoop, referenceCleanupLoop};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
      pinPrev_q <= '0;
    end else begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
    end
  end

  logic cleanLevel;
  logic hfLevel;
  logic hfLocked;
  logic oscLevel;
  logic extSysref;
  logic reqPin;
  logic cleanTick;
  logic hfTick;
  logic oscRise;
  logic hfRise;
  logic lockRise;

  assign cleanLevel = pinSync_q[0];
  assign hfLevel = pinSync_q[1];
  assign hfLocked = pinSync_q[2];
  assign oscLevel = pinSync_q[3];
  assign extSysref = pinSync_q[4];
  assign reqPin = pinSync_q[5];
  // both edges give half-period ticks, the unit of divider and coarse delay
  assign cleanTick = cleanLevel ^ pinPrev_q[0];
  assign hfTick = hfLevel ^ pinPrev_q[1];
  assign hfRise = risingEdge(pinPrev_q[1], hfLevel);
  assign lockRise = risingEdge(pinPrev_q[2], hfLocked);
  assign oscRise = risingEdge(pinPrev_q[3], oscLevel);

  // ====================================================================
  // register file
  channel_cfg_t cfg_q [NUM_CHANNELS];
  logic [7:0] syncCtrl_q;
  logic [NUM_CHANNELS-1:0] ignoreMask_q;
  logic [7:0] sreqCtrl_q;
  logic [7:0] srefMode_q;
  logic [NUM_CHANNELS-1:0] powerdown_q;
  logic [NUM_CHANNELS-1:0] regPowerdown_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        cfg_q[i] <= CFG_RESET;
      end
    end else if (regWrEn) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        if (regAddr == chanAddr(i, CH_DIV_BYTE)) begin
          cfg_q[i].divMinusOne <= regWrData;
        end
        if (regAddr == chanAddr(i, CH_DELAY_BYTE)) begin
          cfg_q[i].coarse <= regWrData[COARSE_LSB +: 6];
          cfg_q[i].source <= regWrData[SRC_LSB +: 2];
        end
        if (regAddr == chanAddr(i, CH_FINE_BYTE)) begin
          cfg_q[i].fineCode <= regWrData[FINE_CODE_LSB +: 4];
          cfg_q[i].fineEnable <= regWrData[FINE_EN_BIT];
          cfg_q[i].bypass <= regWrData[BYPASS_BIT];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncCtrl_q <= BYTE_RESET;
      ignoreMask_q <= MASK_RESET;
      sreqCtrl_q <= BYTE_RESET;
      srefMode_q <= BYTE_RESET;
      powerdown_q <= MASK_RESET;
      regPowerdown_q <= MASK_RESET;
    end else if (regWrEn) begin
      unique case (regAddr)
        SYNC_CTRL_ADDR: syncCtrl_q <= regWrData;
        IGNORE_LOW_ADDR: ignoreMask_q[MASK_LOW_BITS-1:0] <= regWrData;
        IGNORE_HIGH_ADDR: begin
          ignoreMask_q[NUM_CHANNELS-1:MASK_LOW_BITS] <= regWrData[MASK_HIGH_BITS-1:0];
        end
        SREQ_CTRL_ADDR: sreqCtrl_q <= regWrData;
        SREF_MODE_ADDR: srefMode_q <= regWrData;
        PD_LOW_ADDR: powerdown_q[MASK_LOW_BITS-1:0] <= regWrData;
        PD_HIGH_ADDR: begin
          powerdown_q[NUM_CHANNELS-1:MASK_LOW_BITS] <= regWrData[MASK_HIGH_BITS-1:0];
        end
        REG_PD_LOW_ADDR: regPowerdown_q[MASK_LOW_BITS-1:0] <= regWrData;
        REG_PD_HIGH_ADDR: begin
          regPowerdown_q[NUM_CHANNELS-1:MASK_LOW_BITS] <= regWrData[MASK_HIGH_BITS-1:0];
        end
        default: ;
      endcase
    end
  end

  // ====================================================================
  // sync control
  logic syncBitPrev_q;
  logic autoSyncDone_q;
  logic syncBit;
  logic doSync;

  assign syncBit = syncCtrl_q[SYNC_BIT];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncBitPrev_q <= 1'b0;
    end else begin
      syncBitPrev_q <= syncBit;
    end
  end

  // only reset clears the done flag, so later relocks never resync
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      autoSyncDone_q <= 1'b0;
    end else if (lockRise) begin
      autoSyncDone_q <= 1'b1;
    end
  end

  assign doSync = fallingEdge(syncBitPrev_q, syncBit)
                | (lockRise & ~autoSyncDone_q);

  // ====================================================================
  // SYSREF source selection
  logic [1:0] srefMode;
  logic swRequest;
  logic retimeSel;
  logic retimed_q;
  logic internalRef_q;
  logic sysrefSig;

  assign srefMode = srefMode_q[MODE_LSB +: 2];
  assign swRequest = srefMode_q[SW_REQ_BIT];
  assign retimeSel = sreqCtrl_q[RETIME_SEL_BIT];

  // retime on the oscillator or on the feedback node as selected
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      retimed_q <= 1'b0;
    end else if (retimeSel ? hfRise : oscRise) begin
      retimed_q <= extSysref;
    end
  end

  // simple stand-in pattern: square wave on oscillator edges while requested
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      internalRef_q <= 1'b0;
    end else if (!srefMode[1] || !(reqPin || swRequest)) begin
      internalRef_q <= 1'b0;
    end else if (oscRise) begin
      internalRef_q <= ~internalRef_q;
    end
  end

  always_comb begin
    if (srefMode[1]) begin
      sysrefSig = internalRef_q;
    end else if (srefMode == SREF_RETIMED) begin
      sysrefSig = retimed_q;
    end else begin
      sysrefSig = extSysref;
    end
  end

  // ====================================================================
  // channels
  logic [NUM_CHANNELS-1:0] divOut_q;
  logic [NUM_CHANNELS-1:0] divPrev_q;
  logic [NUM_CHANNELS-1:0] running_q;
  logic [NUM_CHANNELS-1:0] delaying_q;
  logic [NUM_CHANNELS-1:0] sysrefRetimed_q;
  logic [7:0] halfCnt_q [NUM_CHANNELS];
  logic [7:0] activeDiv_q [NUM_CHANNELS];
  logic [5:0] delayCnt_q [NUM_CHANNELS];

  for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_channel
    logic isSysref;
    logic divTick;
    logic chanSync;
    logic rawOut;

    assign isSysref = cfg_q[ch].source[1];
    // SYSREF channels clock their divider from the hf loop
    assign divTick = (cfg_q[ch].source == SRC_CLEANUP) ? cleanTick : hfTick;
    assign chanSync = doSync & ~ignoreMask_q[ch] & ~cfg_q[ch].bypass;

    // divider counts half periods: N per level keeps odd ratios at 50%
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        activeDiv_q[ch] <= BYTE_RESET;
        halfCnt_q[ch] <= BYTE_RESET;
        delayCnt_q[ch] <= DELAY_RESET;
        divOut_q[ch] <= 1'b0;
        running_q[ch] <= 1'b0;
        delaying_q[ch] <= 1'b0;
      end else if (chanSync) begin
        activeDiv_q[ch] <= cfg_q[ch].divMinusOne;
        delayCnt_q[ch] <= cfg_q[ch].coarse;
        halfCnt_q[ch] <= BYTE_RESET;
        divOut_q[ch] <= 1'b0;
        running_q[ch] <= (cfg_q[ch].coarse == DELAY_RESET);
        delaying_q[ch] <= (cfg_q[ch].coarse != DELAY_RESET);
      end else if (delaying_q[ch]) begin
        if (delayCnt_q[ch] == DELAY_RESET) begin
          delaying_q[ch] <= 1'b0;
          running_q[ch] <= 1'b1;
        end else if (hfTick) begin
          delayCnt_q[ch] <= delayCnt_q[ch] - 6'h01;
        end
      end else if (running_q[ch] && divTick) begin
        if (halfCnt_q[ch] == activeDiv_q[ch]) begin
          halfCnt_q[ch] <= BYTE_RESET;
          divOut_q[ch] <= ~divOut_q[ch];
        end else begin
          halfCnt_q[ch] <= halfCnt_q[ch] + 8'h01;
        end
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        divPrev_q[ch] <= 1'b0;
        sysrefRetimed_q[ch] <= 1'b0;
      end else begin
        divPrev_q[ch] <= divOut_q[ch];
        if (risingEdge(divPrev_q[ch], divOut_q[ch])) begin
          sysrefRetimed_q[ch] <= sysrefSig;
        end
      end
    end

    always_comb begin
      if (cfg_q[ch].bypass) begin
        rawOut = isSysref ? sysrefSig : (cfg_q[ch].source == SRC_HF ? hfLevel : cleanLevel);
      end else begin
        rawOut = isSysref ? sysrefRetimed_q[ch] : divOut_q[ch];
      end
    end

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        channelOut[ch] <= 1'b0;
      end else if (powerdown_q[ch]) begin
        channelOut[ch] <= channelOut[ch];
      end else if ((syncBit || syncBitPrev_q) && !ignoreMask_q[ch]) begin
        channelOut[ch] <= 1'b0;
      end else begin
        channelOut[ch] <= rawOut;
      end
    end

    // fine delay is analog and follows any source, bypass or not
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        fineDelayEnable[ch] <= 1'b0;
        fineDelayCode[ch] <= 4'h0;
      end else begin
        fineDelayEnable[ch] <= cfg_q[ch].fineEnable;
        fineDelayCode[ch] <= cfg_q[ch].fineCode;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      channelPowerdown <= MASK_RESET;
      regulatorPowerdown <= MASK_RESET;
    end else begin
      channelPowerdown <= powerdown_q;
      regulatorPowerdown <= regPowerdown_q;
    end
  end

  // ====================================================================
  // readback
  logic [7:0] rdMux;

  always_comb begin
    rdMux = BYTE_RESET;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      if (regAddr == chanAddr(i, CH_DIV_BYTE)) begin
        rdMux = cfg_q[i].divMinusOne;
      end
      if (regAddr == chanAddr(i, CH_DELAY_BYTE)) begin
        rdMux = {cfg_q[i].source, cfg_q[i].coarse};
      end
      if (regAddr == chanAddr(i, CH_FINE_BYTE)) begin
        rdMux = {2'h0, cfg_q[i].bypass, cfg_q[i].fineEnable, cfg_q[i].fineCode};
      end
    end
    unique case (regAddr)
      SYNC_CTRL_ADDR: rdMux = syncCtrl_q;
      IGNORE_LOW_ADDR: rdMux = ignoreMask_q[MASK_LOW_BITS-1:0];
      IGNORE_HIGH_ADDR: rdMux = {2'h0, ignoreMask_q[NUM_CHANNELS-1:MASK_LOW_BITS]};
      SREQ_CTRL_ADDR: rdMux = sreqCtrl_q;
      SREF_MODE_ADDR: rdMux = srefMode_q;
      PD_LOW_ADDR: rdMux = powerdown_q[MASK_LOW_BITS-1:0];
      PD_HIGH_ADDR: rdMux = {2'h0, powerdown_q[NUM_CHANNELS-1:MASK_LOW_BITS]};
      REG_PD_LOW_ADDR: rdMux = regPowerdown_q[MASK_LOW_BITS-1:0];
      REG_PD_HIGH_ADDR: rdMux = {2'h0, regPowerdown_q[NUM_CHANNELS-1:MASK_LOW_BITS]};
      STATUS_ADDR: begin
        rdMux = BYTE_RESET;
        rdMux[STAT_AUTOSYNC_BIT] = autoSyncDone_q;
        rdMux[STAT_LOCK_BIT] = hfLocked;
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= BYTE_RESET;
    end else if (regRdEn) begin
      regRdData <= rdMux;
    end
  end

endmodule // clock_distribution_sysref_sync

// ===== src/clock_distribution_pkg.sv
// constants, register map and channel carrier for the clock distribution block
// ====================================================================
package clock_distribution_pkg;

  // ====================================================================
  // sizes
  localparam int NUM_CHANNELS = 14;
  localparam int CH_STRIDE = 3;
  localparam int MASK_LOW_BITS = 8;
  localparam int MASK_HIGH_BITS = NUM_CHANNELS - MASK_LOW_BITS;

  // ====================================================================
  // register offsets
  localparam logic [15:0] CH_BASE_ADDR = 16'h0300;
  localparam logic [15:0] SYNC_CTRL_ADDR = 16'h032a;
  localparam logic [15:0] IGNORE_LOW_ADDR = 16'h032b;
  localparam logic [15:0] IGNORE_HIGH_ADDR = 16'h032c;
  localparam logic [15:0] SREQ_CTRL_ADDR = 16'h0402;
  localparam logic [15:0] SREF_MODE_ADDR = 16'h0403;
  localparam logic [15:0] PD_LOW_ADDR = 16'h0501;
  localparam logic [15:0] PD_HIGH_ADDR = 16'h0502;
  localparam logic [15:0] REG_PD_LOW_ADDR = 16'h0503;
  localparam logic [15:0] REG_PD_HIGH_ADDR = 16'h0504;
  localparam logic [15:0] STATUS_ADDR = 16'h0505;

  // byte positions within one channel's group
  localparam logic [1:0] CH_DIV_BYTE = 2'h0;
  localparam logic [1:0] CH_DELAY_BYTE = 2'h1;
  localparam logic [1:0] CH_FINE_BYTE = 2'h2;

  // ====================================================================
  // field positions
  localparam int SYNC_BIT = 0;
  localparam int RETIME_SEL_BIT = 4;
  localparam int SW_REQ_BIT = 0;
  localparam int MODE_LSB = 6;
  localparam int COARSE_LSB = 0;
  localparam int SRC_LSB = 6;
  localparam int FINE_CODE_LSB = 0;
  localparam int FINE_EN_BIT = 4;
  localparam int BYPASS_BIT = 5;
  localparam int STAT_AUTOSYNC_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;

  // ====================================================================
  // encodings
  localparam logic [1:0] SRC_CLEANUP = 2'h0;
  localparam logic [1:0] SRC_HF = 2'h1;
  localparam logic [1:0] SREF_DIRECT = 2'h0;
  localparam logic [1:0] SREF_RETIMED = 2'h1;

  // ====================================================================
  // reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [NUM_CHANNELS-1:0] MASK_RESET = 14'h0000;
  localparam logic [5:0] DELAY_RESET = 6'h00;

  // per-channel settings as software wrote them
  typedef struct packed {
    logic [7:0] divMinusOne;
    logic [1:0] source;
    logic [5:0] coarse;
    logic bypass;
    logic fineEnable;
    logic [3:0] fineCode;
  } channel_cfg_t;

  localparam channel_cfg_t CFG_RESET = '0;

endpackage

// ===== sim/clock_distribution_chk.sv
// port-level assertions for the clock distribution block
`timescale 1ns/1ps
module clock_distribution_chk
  import clock_distribution_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic [NUM_CHANNELS-1:0] channelOut,
  input wire logic [NUM_CHANNELS-1:0] fineDelayEnable,
  input wire logic [NUM_CHANNELS-1:0][3:0] fineDelayCode,
  input wire logic [NUM_CHANNELS-1:0] channelPowerdown,
  input wire logic [NUM_CHANNELS-1:0] regulatorPowerdown
);
  // ====
  // shadows of host writes, needed to know which channels sync may hold
  logic syncSh_q;
  logic [NUM_CHANNELS-1:0] ignSh_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncSh_q <= 1'b0;
      ignSh_q <= '0;
    end else if (regWrEn) begin
      if (regAddr == SYNC_CTRL_ADDR) syncSh_q <= regWrData[SYNC_BIT];
      if (regAddr == IGNORE_LOW_ADDR) ignSh_q[7:0] <= regWrData;
      if (regAddr == IGNORE_HIGH_ADDR) ignSh_q[13:8] <= regWrData[5:0];
    end
  end
  // ====
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sync_hold_a: assert property (
    syncSh_q && $past(syncSh_q) |-> (channelOut & ~ignSh_q) == '0)
    else $error("outputs not held low during sync");
  pd_freeze_a: assert property (
    (channelPowerdown & $past(channelPowerdown) & $past(channelPowerdown, 2)
     & (channelOut ^ $past(channelOut))) == '0)
    else $error("powered-down output moved");
  pd_low_copy_a: assert property (
    regWrEn && regAddr == PD_LOW_ADDR
    |=> ##1 channelPowerdown[7:0] == $past(regWrData, 2))
    else $error("power-down low bits wrong");
  pd_high_copy_a: assert property (
    regWrEn && regAddr == PD_HIGH_ADDR
    |=> ##1 channelPowerdown[13:8] == $past(regWrData[5:0], 2))
    else $error("power-down high bits wrong");
  reg_pd_low_a: assert property (
    regWrEn && regAddr == REG_PD_LOW_ADDR
    |=> ##1 regulatorPowerdown[7:0] == $past(regWrData, 2))
    else $error("regulator power-down low bits wrong");
  reg_pd_high_a: assert property (
    regWrEn && regAddr == REG_PD_HIGH_ADDR
    |=> ##1 regulatorPowerdown[13:8] == $past(regWrData[5:0], 2))
    else $error("regulator power-down high bits wrong");
  fine_first_a: assert property (
    regWrEn && regAddr == CH_BASE_ADDR + 16'h2
    |=> ##1 fineDelayCode[0] == $past(regWrData[3:0], 2)
    && fineDelayEnable[0] == $past(regWrData[FINE_EN_BIT], 2))
    else $error("fine delay of first channel wrong");
  fine_last_a: assert property (
    regWrEn && regAddr == CH_BASE_ADDR + 16'h29
    |=> ##1 fineDelayCode[13] == $past(regWrData[3:0], 2)
    && fineDelayEnable[13] == $past(regWrData[FINE_EN_BIT], 2))
    else $error("fine delay of last channel wrong");
  unmapped_read_a: assert property (
    regRdEn && regAddr == 16'h0600 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  mask_read_a: assert property (
    regRdEn && regAddr == IGNORE_HIGH_ADDR |=> regRdData[7:6] == 2'b00)
    else $error("unused mask bits read nonzero");
  pd_readback_a: assert property (
    regRdEn && !regWrEn && regAddr == PD_LOW_ADDR |=> regRdData == channelPowerdown[7:0])
    else $error("power-down readback differs from port");
endmodule // clock_distribution_chk

bind clock_distribution_sysref_sync clock_distribution_chk chk (.clk, .reset_n, .regAddr,
  .regWrData, .regWrEn, .regRdEn, .regRdData, .channelOut, .fineDelayEnable, .fineDelayCode,
  .channelPowerdown, .regulatorPowerdown);

// ===== sim/clock_source_model.sv
// loop, oscillator and external SYSREF sources feeding the block
`timescale 1ns/1ps
module clock_source_model #(
  parameter int CL_HALF = 6,
  parameter int HF_HALF = 4,
  parameter int OSC_HALF = 5,
  parameter int SR_HALF = 20
) (
  input wire logic clk,
  input wire logic sysrefRun,
  output logic cleanupOut,
  output logic hfOut,
  output logic oscOut,
  output logic sysrefOut
);
  // ====
  // free-running sources; SYSREF idles low when not running
  int cnt = 0;
  always @(posedge clk) begin
    cnt <= cnt + 1;
  end
  assign cleanupOut = (cnt / CL_HALF) % 2 == 1;
  assign hfOut = (cnt / HF_HALF) % 2 == 1;
  assign oscOut = (cnt / OSC_HALF) % 2 == 1;
  assign sysrefOut = sysrefRun && ((cnt / SR_HALF) % 2 == 1);
endmodule // clock_source_model

// ===== sim/clock_distribution_sysref_sync_tb.sv
// self-checking testbench for the clock distribution block
`timescale 1ns/1ps
module clock_distribution_sysref_sync_tb;
  import clock_distribution_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] regAddr = '0;
  logic [7:0] regWrData = '0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regRdData;
  logic referenceCleanupLoop, highFrequencyLoop, oscillatorClockInput, externalSysrefInput;
  logic highFrequencyLoopLocked = 1'b0;
  logic sysrefRequestPin = 1'b0;
  logic sysrefRun = 1'b0;
  logic [NUM_CHANNELS-1:0] channelOut, fineDelayEnable, channelPowerdown, regulatorPowerdown;
  logic [NUM_CHANNELS-1:0][3:0] fineDelayCode;
  int errCount = 0;
  int compares = 0;

  clock_distribution_sysref_sync DUT (.clk, .reset_n, .regAddr, .regWrData, .regWrEn,
    .regRdEn, .regRdData, .referenceCleanupLoop, .highFrequencyLoop, .highFrequencyLoopLocked,
    .oscillatorClockInput, .externalSysrefInput, .sysrefRequestPin, .channelOut,
    .fineDelayEnable, .fineDelayCode, .channelPowerdown, .regulatorPowerdown);
  clock_source_model src (.clk, .sysrefRun, .cleanupOut(referenceCleanupLoop),
    .hfOut(highFrequencyLoop), .oscOut(oscillatorClockInput), .sysrefOut(externalSysrefInput));

  initial begin
    forever #25 clk = ~clk;
  end
  // ====
  // access and checking tasks
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errCount++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk); #5;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clk); #5;
    regWrEn = 1'b0;
  endtask
  task automatic rdChk(input string what, input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk); #5;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge clk); #5;
    regRdEn = 1'b0;
    chk(what, {8'h00, regRdData}, {8'h00, exp});
  endtask
  task automatic cfgCh(input int ch, input logic [7:0] dv, input logic [7:0] dl,
                       input logic [7:0] fn);
    wr(CH_BASE_ADDR + 16'(3 * ch), dv);
    wr(CH_BASE_ADDR + 16'(3 * ch + 1), dl);
    wr(CH_BASE_ADDR + 16'(3 * ch + 2), fn);
  endtask
  task automatic chg(input int ch, input int n, output int c);
    logic p;
    c = 0;
    p = channelOut[ch];
    repeat (n) begin
      @(posedge clk); #5;
      if (channelOut[ch] !== p) c++;
      p = channelOut[ch];
    end
  endtask
  // waits for a rising output, then times one high and one low phase
  task automatic meas(input int ch, output int hi, output int lo);
    int n;
    n = 0;
    hi = 0;
    lo = 0;
    while (channelOut[ch] !== 1'b0 && n < 3000) begin @(posedge clk); #5; n++; end
    while (channelOut[ch] !== 1'b1 && n < 3000) begin @(posedge clk); #5; n++; end
    while (channelOut[ch] === 1'b1 && hi < 3000) begin @(posedge clk); #5; hi++; end
    while (channelOut[ch] === 1'b0 && lo < 3000) begin @(posedge clk); #5; lo++; end
  endtask
  // ====
  // watchdog, about seven times the expected run
  initial begin
    repeat (30000) @(posedge clk);
    errCount++;
    $display("Error watchdog expected finish seen timeout");
    results();
  end
  // ====
  // tests
  initial begin
    logic [15:0] regs [9];
    logic [7:0] sm [7];
    logic [7:0] sq [7];
    logic [2:0] ctl [7];
    int c, h, l, t0, t3, n;
    regs = '{SYNC_CTRL_ADDR, IGNORE_LOW_ADDR, IGNORE_HIGH_ADDR, SREQ_CTRL_ADDR,
             SREF_MODE_ADDR, PD_LOW_ADDR, PD_HIGH_ADDR, REG_PD_LOW_ADDR, REG_PD_HIGH_ADDR};
    // mode byte, retime byte, {run, pin, activity expected}
    sm = '{8'h01, 8'h41, 8'h41, 8'h00, 8'h80, 8'h81, 8'h80};
    sq = '{8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
    ctl = '{3'b010, 3'b101, 3'b101, 3'b101, 3'b000, 3'b001, 3'b011};
    repeat (20) @(posedge clk);
    #5;
    reset_n = 1'b1;
    foreach (regs[i]) rdChk("reset value", regs[i], 8'h00);
    rdChk("unmapped read", 16'h0600, 8'h00);
    wr(IGNORE_HIGH_ADDR, 8'hff);
    rdChk("mask high", IGNORE_HIGH_ADDR, 8'h3f);
    wr(PD_LOW_ADDR, 8'ha5);
    wr(PD_HIGH_ADDR, 8'h2c);
    wr(REG_PD_LOW_ADDR, 8'h5a);
    wr(REG_PD_HIGH_ADDR, 8'h13);
    @(posedge clk);
    #5;
    chk("powerdown", {2'b00, channelPowerdown}, 16'h2ca5);
    chk("regulator", {2'b00, regulatorPowerdown}, 16'h135a);
    rdChk("powerdown high", PD_HIGH_ADDR, 8'h2c);
    for (int i = 2; i < 9; i++) wr(regs[i], 8'h00);
    $display("test registers done");
    cfgCh(0, 8'h02, 8'h40, 8'h00);
    cfgCh(1, 8'h00, 8'h00, 8'h00);
    cfgCh(2, 8'hff, 8'h40, 8'h00);
    cfgCh(3, 8'h02, 8'h45, 8'h00);
    cfgCh(4, 8'h00, 8'h80, 8'h3f);
    cfgCh(5, 8'h00, 8'h40, 8'h10);
    cfgCh(13, 8'h00, 8'h00, 8'h1a);
    @(posedge clk);
    #5;
    chk("fine enables", {2'b00, fineDelayEnable}, 16'h2030);
    chk("fine max", {12'h000, fineDelayCode[4]}, 16'h000f);
    chk("fine min", {12'h000, fineDelayCode[5]}, 16'h0000);
    chg(0, 60, c);
    chk("idle before lock", 16'(c), 16'h0000);
    highFrequencyLoopLocked = 1'b1;
    meas(0, h, l);
    chk("ratio 3 high", 16'(h), 16'd12);
    chk("ratio 3 low", 16'(l), 16'd12);
    meas(1, h, l);
    chk("ratio 1 high", 16'(h), 16'd6);
    meas(2, h, l);
    chk("ratio 256 high", 16'(h), 16'd1024);
    chk("ratio 256 low", 16'(l), 16'd1024);
    rdChk("status", STATUS_ADDR, 8'h03);
    $display("test auto sync done");
    wr(IGNORE_LOW_ADDR, 8'h02);
    wr(SYNC_CTRL_ADDR, 8'h01);
    wr(CH_BASE_ADDR + 16'h6, 8'h01);
    chg(0, 40, c);
    chk("held output", {15'h0, channelOut[0]} | 16'(c), 16'h0000);
    chg(1, 40, c);
    chk("ignored output runs", 16'(c > 0), 16'h0001);
    wr(SYNC_CTRL_ADDR, 8'h00);
    t0 = -1;
    t3 = -1;
    n = 0;
    while ((t0 < 0 || t3 < 0) && n < 500) begin
      @(posedge clk); #5;
      n++;
      if (t0 < 0 && channelOut[0] === 1'b1) t0 = n;
      if (t3 < 0 && channelOut[3] === 1'b1) t3 = n;
    end
    chk("coarse offset", 16'(t3 - t0), 16'd20);
    meas(2, h, l);
    chk("new ratio high", 16'(h), 16'd8);
    $display("test sync done");
    wr(PD_LOW_ADDR, 8'h01);
    chg(0, 3, c);
    chg(0, 40, c);
    chk("frozen output", 16'(c), 16'h0000);
    wr(PD_LOW_ADDR, 8'h00);
    chg(0, 40, c);
    chk("released output", 16'(c > 0), 16'h0001);
    $display("test power-down done");
    for (int i = 0; i < 7; i++) begin
      sysrefRun = ctl[i][2];
      sysrefRequestPin = ctl[i][1];
      wr(SREQ_CTRL_ADDR, sq[i]);
      wr(SREF_MODE_ADDR, sm[i]);
      chg(4, 8, c);
      chg(4, 80, c);
      chk("sysref activity", 16'(c > 0), {15'h0, ctl[i][0]});
    end
    $display("test sysref modes done");
    results();
  end
endmodule // clock_distribution_sysref_sync_tb
